// ===== hw/lpc_bridge_general_control.sv
`timescale 1ns/100ps
module lpc_bridge_general_control
  import gen_ctl_pkg::*;
(
  input  wire logic              pclk,                       // Core clock, 50 MHz.
  input  wire logic              presetn,                    // Core-well reset, active low.
  input  wire logic              rtc_rst_n,                  // RTC-well reset, active low.
  input  wire logic              psel,                       // APB select.
  input  wire logic              penable,                    // APB access phase.
  input  wire logic              pwrite,                     // APB write.
  input  wire logic [ADDR_W-1:0] paddr,                      // APB byte address.
  input  wire logic [31:0]       pwdata,                     // APB write data.
  output logic      [31:0]       prdata,                     // APB read data.
  output logic                   pready,                     // APB ready.
  output logic                   pslverr,                    // APB error, unmapped address.
  input  wire logic              fp_error_in_n,              // Coprocessor error pin, active low.
  input  wire logic              cpu_reset_in_n,             // Processor reset, active low.
  input  wire logic              kbd_irq_in,                 // Keyboard interrupt pin.
  input  wire logic              mouse_irq_in,               // Mouse interrupt pin.
  input  wire logic [3:0]        strap_in,                   // Strap pins for status low nibble.
  input  wire logic              port_f0_write,              // I/O write to port F0h, pulse.
  input  wire logic              port_60_read,               // I/O read of port 60h, pulse.
  input  wire logic              pci_cycle_start,            // New PCI cycle address phase, pulse.
  input  wire logic              pci_hit_internal,           // Address hits an internal register.
  input  wire logic              pci_hit_known_lpc,          // Address hits a known LPC target.
  output logic                   irq13_out,                  // Internal interrupt 13.
  output logic                   ignore_numeric_error_out_n, // Ignore numeric error, active low.
  output logic                   irq1_out,                   // Keyboard interrupt downstream.
  output logic                   irq12_out,                  // Mouse interrupt downstream.
  output logic                   cpu_init_out_n,             // Processor init, active low.
  output logic                   io_intctl_on,               // I/O interrupt controller enable.
  output logic                   alternate_access_enable,    // Alternate access mode.
  output logic                   dma_collect_buffer_enable,  // DMA collection buffer enable.
  output logic                   delayed_txn_enable,         // Delayed transaction enable.
  output logic                   positive_decode_enable,     // Positive decode only.
  output logic                   claim_positive,             // Claim with positive timing, pulse.
  output logic                   claim_subtractive,          // Claim and forward to LPC, pulse.
  output logic                   irq_out                     // Summary interrupt, level.
);

  typedef struct packed {
    logic [PIN_W-1:0] sync1;
    logic [PIN_W-1:0] sync2;
    logic [31:0]      ctrl;
    logic [3:0]       strap;
    logic [1:0]       strap_cnt;
    logic             strap_taken;
    logic             irq13;
    logic             ign_err_n;
    logic             irq1;
    logic             irq12;
    logic             init_n;
    logic [1:0]       hold_cnt;
    logic             claim_pos;
    logic             claim_sub;
    logic [EV_W-1:0]  ev_sta;
    logic [EV_W-1:0]  ev_mask;
    logic             irq;
    logic [31:0]      rdata;
    logic             ready;
    logic             slverr;
  } core_state_t;

  typedef struct packed {
    logic       selftest;
    logic [3:0] freq;
  } rtc_state_t;

  core_state_t s_reg;
  core_state_t s_next;
  rtc_state_t  r_reg;
  rtc_state_t  r_next;

  irq_latch_if lk [2] ();

  logic [PIN_W-1:0] pins;
  logic             fp_err;
  logic             cpu_rst;
  logic             setup;
  logic             wr_done;
  logic             rd_done;
  logic             hit_ctl;
  logic             hit_sta;
  logic             hit_evs;
  logic             hit_evm;
  logic [EV_W-1:0]  events;
  logic [31:0]      sta_view;
  logic             known;

  assign pins = {strap_in, mouse_irq_in, kbd_irq_in, cpu_reset_in_n, fp_error_in_n};

  // Keyboard and mouse interrupts share one edge-latch design, both cleared by a port 60h read.
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_latch
      assign lk[g].latch_en = s_reg.ctrl[g == 0 ? CTL_KBD_LATCH : CTL_MOUSE_LATCH]; // RULE4 RULE5
      assign lk[g].raw      = s_reg.sync2[g == 0 ? PIN_KBD : PIN_MOUSE];
      assign lk[g].clear    = port_60_read;                                         // RULE4 RULE5
      irq_edge_latch u_latch (
        .pclk    (pclk),
        .presetn (presetn),
        .lk      (lk[g])
      );
    end
  endgenerate

  assign fp_err   = ~s_reg.sync2[PIN_FP_ERR_N];
  assign cpu_rst  = ~s_reg.sync2[PIN_CPU_RST_N];
  assign setup    = psel & ~penable;
  assign wr_done  = psel & penable & s_reg.ready & pwrite;
  assign rd_done  = psel & penable & s_reg.ready & ~pwrite;
  assign hit_ctl  = (paddr == GENERAL_CONTROL_ADDR);
  assign hit_sta  = (paddr == GENERAL_STATUS_ADDR);
  assign hit_evs  = (paddr == EV_STA_ADDR);
  assign hit_evm  = (paddr == EV_MASK_ADDR);
  assign known    = pci_hit_internal | pci_hit_known_lpc;

  // Bits 7:4 and 31:13 are reserved and read back as zero.
  assign sta_view = {19'h0, r_reg.selftest, r_reg.freq, 4'h0, s_reg.strap}; // RULE16 RULE17

  always_comb begin
    s_next = s_reg;
    r_next = r_reg;
    events = '0;

    s_next.sync1 = pins;
    s_next.sync2 = s_reg.sync1;

    // The strap nibble is taken once the synchroniser has filled after reset.
    if (!s_reg.strap_taken) begin
      if (s_reg.strap_cnt == STRAP_WAIT_CYC) begin
        s_next.strap       = s_reg.sync2[7:4];                                 // RULE16
        s_next.strap_taken = 1'b1;
      end else begin
        s_next.strap_cnt = s_reg.strap_cnt + 2'h1;
      end
    end

    // Interrupt 13 latches until the port F0h write; a new error in that cycle keeps it set.
    s_next.irq13   = s_reg.ctrl[CTL_COPROC_ERR] & (fp_err | (s_reg.irq13 & ~port_f0_write)); // RULE1 RULE3
    s_next.ign_err_n = ~(s_reg.ctrl[CTL_COPROC_ERR] & fp_err);                 // RULE2 RULE3

    s_next.irq1  = lk[0].level;                                                // RULE4
    s_next.irq12 = lk[1].level;                                                // RULE5

    // Init follows processor reset while self-test is on and trails its release by the hold time.
    if (r_reg.selftest && cpu_rst) begin
      s_next.init_n   = 1'b0;                                                  // RULE13
      s_next.hold_cnt = CPU_HOLD_CYC;
    end else if (!s_reg.init_n) begin
      if (s_reg.hold_cnt == 2'h0) begin
        s_next.init_n = 1'b1;                                                  // RULE14
      end else begin
        s_next.hold_cnt = s_reg.hold_cnt - 2'h1;                               // RULE14
      end
    end

    events[EV_IRQ13] = s_next.irq13 & ~s_reg.irq13;
    events[EV_KBD]   = s_reg.ctrl[CTL_KBD_LATCH] & lk[0].edge_seen;
    events[EV_MOUSE] = s_reg.ctrl[CTL_MOUSE_LATCH] & lk[1].edge_seen;
    events[EV_INIT]  = ~s_next.init_n & s_reg.init_n;

    // Known targets are always claimed with positive timing; the rest only when subtractive.
    s_next.claim_pos = pci_cycle_start & known;                                // RULE10 RULE12
    s_next.claim_sub = pci_cycle_start & ~known & ~s_reg.ctrl[CTL_POS_DEC];    // RULE11

    // APB: read data is formed in the setup cycle so the access phase completes at once.
    s_next.ready  = setup;
    s_next.slverr = setup & ~(hit_ctl | hit_sta | hit_evs | hit_evm);
    s_next.rdata  = 32'h0;
    if (setup && !pwrite) begin
      case (1'b1)
        hit_ctl: s_next.rdata = s_reg.ctrl;
        hit_sta: s_next.rdata = sta_view;
        hit_evs: s_next.rdata = {28'h0, s_reg.ev_sta};
        hit_evm: s_next.rdata = {28'h0, s_reg.ev_mask};
        default: s_next.rdata = 32'h0;
      endcase
    end

    if (wr_done) begin
      if (hit_ctl) begin
        s_next.ctrl = pwdata & CTL_WMASK;                                      // RULE6 RULE7 RULE8 RULE9 RULE17
      end
      if (hit_sta) begin
        r_next.selftest = pwdata[STA_SELFTEST];                                // RULE15
        r_next.freq     = pwdata[11:8];                                        // RULE15
        if (s_reg.ctrl[CTL_ALT_ACC]) begin
          s_next.strap = pwdata[3:0];                                          // RULE7
        end
      end
      if (hit_evm) begin
        s_next.ev_mask = pwdata[EV_W-1:0];
      end
    end

    // A read clears the status, except in alternate access mode; new events always win.
    if (rd_done && hit_evs && !s_reg.ctrl[CTL_ALT_ACC]) begin
      s_next.ev_sta = events;                                                  // RULE7
    end else begin
      s_next.ev_sta = s_reg.ev_sta | events;
    end
    s_next.irq = |(s_next.ev_sta & s_next.ev_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg             <= '0;
      s_reg.sync1       <= PIN_SYNC_RESET;
      s_reg.sync2       <= PIN_SYNC_RESET;
      s_reg.ctrl        <= CTL_RESET;                                          // RULE7
      s_reg.ign_err_n   <= 1'b1;
      s_reg.init_n      <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // Self-test enable and frequency nibble sit in the battery well and survive core reset.
  always_ff @(posedge pclk or negedge rtc_rst_n) begin
    if (!rtc_rst_n) begin
      r_reg.selftest <= STA_SELFTEST_RESET;                                    // RULE15 RULE16
      r_reg.freq     <= STA_FREQ_RESET;                                        // RULE16
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata                     = s_reg.rdata;
  assign pready                     = s_reg.ready;
  assign pslverr                    = s_reg.slverr;
  assign irq13_out                  = s_reg.irq13;
  assign ignore_numeric_error_out_n = s_reg.ign_err_n;
  assign irq1_out                   = s_reg.irq1;
  assign irq12_out                  = s_reg.irq12;
  assign cpu_init_out_n             = s_reg.init_n;
  assign io_intctl_on               = s_reg.ctrl[CTL_IO_INTCTL];               // RULE6
  assign alternate_access_enable    = s_reg.ctrl[CTL_ALT_ACC];                 // RULE7
  assign dma_collect_buffer_enable  = s_reg.ctrl[CTL_DMA_BUF];                 // RULE8
  assign delayed_txn_enable         = s_reg.ctrl[CTL_DLY_TXN];                 // RULE9
  assign positive_decode_enable     = s_reg.ctrl[CTL_POS_DEC];                 // RULE10
  assign claim_positive             = s_reg.claim_pos;
  assign claim_subtractive          = s_reg.claim_sub;
  assign irq_out                    = s_reg.irq;

endmodule // lpc_bridge_general_control

// ===== hw/gen_ctl_pkg.sv
// Function
// RULE1: FP error with enable raises irq13 until F0.
// RULE2: FP error with enable drives ignore-error output.
// RULE3: Enable clear blocks irq13 and ignore-error.
// RULE4: Keyboard irq edge latched until port 60 read.
// RULE5: Mouse irq edge latched until port 60 read.
// RULE6: Bit 8 enables the I/O interrupt controller.
// RULE7: Bit 6 opens alternate access, default off.
// RULE8: Bit 2 enables the DMA collection buffer.
// RULE9: Bit 1 enables delayed transactions.
// RULE10: Bit 0 set claims positive decode only.
// RULE11: Bit 0 clear claims unknown cycles subtractively.
// RULE12: Known targets still claimed with positive timing.
// RULE13: Self-test bit drives init during cpu reset.
// RULE14: Init released after reset with hold time.
// RULE15: Status bits 8-15 live in RTC well; the code keeps only bits 8-12 there, and bits 13-15 read zero.
// RULE16: Status resets to 00000F0X, low nibble strapped.
// RULE17: Reserved bits read zero, writes ignored.
package gen_ctl_pkg;

  localparam int          ADDR_W          = 12;
  localparam logic [11:0] GENERAL_CONTROL_ADDR = 12'h0d0;
  localparam logic [11:0] GENERAL_STATUS_ADDR  = 12'h0d4;
  localparam logic [11:0] EV_STA_ADDR     = 12'h100;
  localparam logic [11:0] EV_MASK_ADDR    = 12'h104;

  localparam int          CTL_POS_DEC     = 0;
  localparam int          CTL_DLY_TXN     = 1;
  localparam int          CTL_DMA_BUF     = 2;
  localparam int          CTL_ALT_ACC     = 6;
  localparam int          CTL_IO_INTCTL   = 8;
  localparam int          CTL_MOUSE_LATCH = 11;
  localparam int          CTL_KBD_LATCH   = 12;
  localparam int          CTL_COPROC_ERR  = 13;
  localparam logic [31:0] CTL_WMASK       = 32'h0000_3947;
  localparam logic [31:0] CTL_RESET       = 32'h0000_0000;

  localparam int          STA_SELFTEST    = 12;
  localparam logic [3:0]  STA_FREQ_RESET  = 4'hf;
  localparam logic        STA_SELFTEST_RESET = 1'b0;

  localparam int          EV_IRQ13        = 0;
  localparam int          EV_KBD          = 1;
  localparam int          EV_MOUSE        = 2;
  localparam int          EV_INIT         = 3;
  localparam int          EV_W            = 4;

  localparam int          PIN_FP_ERR_N    = 0;
  localparam int          PIN_CPU_RST_N   = 1;
  localparam int          PIN_KBD         = 2;
  localparam int          PIN_MOUSE       = 3;
  localparam int          PIN_W           = 8;
  localparam logic [7:0]  PIN_SYNC_RESET  = 8'h03;

  localparam int          CLK_PERIOD_NS   = 20;
  localparam int          CPU_HOLD_NS     = 60;
  localparam logic [1:0]  CPU_HOLD_CYC    = 2'((CPU_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [1:0]  STRAP_WAIT_CYC  = 2'h2;

endpackage

// ===== hw/irq_latch_if.sv
`timescale 1ns/100ps
interface irq_latch_if;
  logic latch_en;   // Latch mode selected.
  logic raw;        // Synchronised interrupt level.
  logic clear;      // Port 60h read pulse.
  logic level;      // Interrupt as seen downstream.
  logic edge_seen;  // Rising edge of raw this cycle.

  modport latch (input latch_en, input raw, input clear, output level, output edge_seen);
  modport user  (output latch_en, output raw, output clear, input level, input edge_seen);
endinterface

// ===== hw/irq_edge_latch.sv
`timescale 1ns/100ps
module irq_edge_latch (
  input wire logic  pclk,     // Core clock.
  input wire logic  presetn,  // Asynchronous reset, active low.
  irq_latch_if.latch lk       // Latch control and result.
);

  typedef struct packed {
    logic prev;
    logic held;
  } latch_state_t;

  latch_state_t s_reg;
  latch_state_t s_next;

  // A new edge in the clearing cycle keeps the latch set.
  always_comb begin
    s_next      = s_reg;
    s_next.prev = lk.raw;
    s_next.held = lk.latch_en & ((lk.raw & ~s_reg.prev) | (s_reg.held & ~lk.clear));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign lk.level     = lk.latch_en ? s_reg.held : lk.raw;
  assign lk.edge_seen = lk.raw & ~s_reg.prev;

endmodule // irq_edge_latch

// ===== tb/gen_ctl_properties.sv
`timescale 1ns/100ps
module gen_ctl_checker
  import gen_ctl_pkg::*;
(
  input wire logic              pclk,                       // Clock.
  input wire logic              presetn,                    // Reset.
  input wire logic              psel,                       // Select.
  input wire logic              penable,                    // Access.
  input wire logic              pwrite,                     // Write.
  input wire logic [ADDR_W-1:0] paddr,                      // Address.
  input wire logic [31:0]       pwdata,                     // Write data.
  input wire logic              pready,                     // Ready.
  input wire logic              pslverr,                    // Error.
  input wire logic              fp_error_in_n,              // Error pin.
  input wire logic              cpu_reset_in_n,             // Reset pin.
  input wire logic              port_f0_write,              // Port write.
  input wire logic              pci_cycle_start,            // Cycle start.
  input wire logic              pci_hit_internal,           // Hit.
  input wire logic              pci_hit_known_lpc,          // Hit.
  input wire logic              irq13_out,                  // Interrupt.
  input wire logic              ignore_numeric_error_out_n, // Ignore.
  input wire logic              cpu_init_out_n,             // Init.
  input wire logic              io_intctl_on,               // Level.
  input wire logic              alternate_access_enable,    // Level.
  input wire logic              dma_collect_buffer_enable,  // Level.
  input wire logic              delayed_txn_enable,         // Level.
  input wire logic              positive_decode_enable,     // Level.
  input wire logic              claim_positive,             // Claim.
  input wire logic              claim_subtractive           // Claim.
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire       ctl_wr  = psel && penable && pready && pwrite && paddr == GENERAL_CONTROL_ADDR;
  wire       ctl13_clr = ctl_wr && !pwdata[CTL_COPROC_ERR];
  wire       nohit   = !pci_hit_internal && !pci_hit_known_lpc;
  wire [4:0] ctl_out = {io_intctl_on, alternate_access_enable, dma_collect_buffer_enable,
                        delayed_txn_enable, positive_decode_enable};
  wire [4:0] ctl_wbits = {pwdata[CTL_IO_INTCTL], pwdata[CTL_ALT_ACC], pwdata[CTL_DMA_BUF],
                          pwdata[CTL_DLY_TXN], pwdata[CTL_POS_DEC]};
  sequence s_setup; psel && !penable; endsequence
  sequence s_init_release; !cpu_init_out_n && $rose(cpu_reset_in_n); endsequence
  sequence s_init_tail; !cpu_init_out_n [*4] ##[1:3] cpu_init_out_n; endsequence
  property p_ready_first; s_setup |=> pready; endproperty
  property p_ready_once; pready |=> !pready; endproperty
  property p_err_ready; pslverr |-> pready; endproperty
  property p_ctl_out; ctl_wr |=> ctl_out == $past(ctl_wbits); endproperty
  property p_ignore_irq; !ignore_numeric_error_out_n |-> irq13_out; endproperty
  property p_ignore_cause; !ignore_numeric_error_out_n |-> !$past(fp_error_in_n, 3); endproperty
  property p_irq13_clear;
    $fell(irq13_out) |-> $past(port_f0_write) || $past(port_f0_write, 2) || $past(ctl13_clr) || $past(ctl13_clr, 2);
  endproperty
  property p_pos_claim; pci_cycle_start && !nohit |=> claim_positive && !claim_subtractive; endproperty
  property p_sub_claim; pci_cycle_start && nohit && !positive_decode_enable |=> claim_subtractive && !claim_positive; endproperty
  property p_pos_only; pci_cycle_start && nohit && positive_decode_enable |=> !claim_subtractive && !claim_positive; endproperty
  property p_init_hold; s_init_release |-> s_init_tail; endproperty
  property p_init_cause; $fell(cpu_init_out_n) |-> !$past(cpu_reset_in_n, 2); endproperty
  a_ready_first: assert property (p_ready_first) else $error("no ready in access cycle");
  a_ready_once: assert property (p_ready_once) else $error("ready held too long");
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  a_ctl_out: assert property (p_ctl_out) else $error("control level mismatch");
  a_ignore_irq: assert property (p_ignore_irq) else $error("ignore without irq13");
  a_ignore_cause: assert property (p_ignore_cause) else $error("ignore without error pin");
  a_irq13_clear: assert property (p_irq13_clear) else $error("irq13 dropped without clear");
  a_pos_claim: assert property (p_pos_claim) else $error("known target not claimed");
  a_sub_claim: assert property (p_sub_claim) else $error("no subtractive claim");
  a_pos_only: assert property (p_pos_only) else $error("claim in positive mode");
  a_init_hold: assert property (p_init_hold) else $error("init release timing");
  a_init_cause: assert property (p_init_cause) else $error("init without reset");
endmodule // gen_ctl_checker

bind lpc_bridge_general_control gen_ctl_checker u_chk (.*);

// ===== tb/cpu_pci_agent.sv
`timescale 1ns/100ps
module cpu_pci_agent
  import gen_ctl_pkg::*;
(
  input  wire logic       pclk,               // Clock.
  output logic            fp_error_in_n,      // Coprocessor error.
  output logic            cpu_reset_in_n,     // Processor reset.
  output logic            kbd_irq_in,         // Keyboard interrupt.
  output logic            mouse_irq_in,       // Mouse interrupt.
  output logic      [3:0] strap_in,           // Straps.
  output logic            pci_cycle_start,    // Address phase.
  output logic            pci_hit_internal,   // Internal hit.
  output logic            pci_hit_known_lpc   // Known target hit.
);
  initial begin
    {fp_error_in_n, cpu_reset_in_n, kbd_irq_in, mouse_irq_in} = 4'hc;
    strap_in = 4'ha;
    {pci_cycle_start, pci_hit_internal, pci_hit_known_lpc} = 3'h2;
  end
  task automatic set_pin(input int which, input logic v);
    @(posedge pclk);
    case (which)
      PIN_FP_ERR_N:  fp_error_in_n <= v;
      PIN_CPU_RST_N: cpu_reset_in_n <= v;
      PIN_KBD:       kbd_irq_in <= v;
      default:       mouse_irq_in <= v;
    endcase
  endtask
  // Hit lines mean nothing outside the start pulse, so they flip afterwards.
  task automatic pci_cycle(input logic hi, input logic hl, input int idle);
    repeat (idle) @(posedge pclk);
    @(posedge pclk);
    pci_cycle_start <= 1'b1;
    pci_hit_internal <= hi;
    pci_hit_known_lpc <= hl;
    @(posedge pclk);
    pci_cycle_start <= 1'b0;
    pci_hit_internal <= ~hi;
    pci_hit_known_lpc <= ~hl;
    #1;
  endtask
endmodule // cpu_pci_agent

// ===== tb/lpc_bridge_general_control_tb.sv
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module lpc_bridge_general_control_tb;
  import gen_ctl_pkg::*;
  logic              pclk, presetn, rtc_rst_n, psel, penable, pwrite, port_f0_write, port_60_read;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata;
  logic [3:0]        strap_in;
  logic              pready, pslverr, fp_error_in_n, cpu_reset_in_n, kbd_irq_in, mouse_irq_in, irq_out;
  logic              pci_cycle_start, pci_hit_internal, pci_hit_known_lpc, irq13_out, ignore_numeric_error_out_n;
  logic              irq1_out, irq12_out, cpu_init_out_n, io_intctl_on, alternate_access_enable;
  logic              dma_collect_buffer_enable, delayed_txn_enable, positive_decode_enable;
  logic              claim_positive, claim_subtractive;
  int                mismatches = 0;
  int                n_tests = 0;
  int                bitpos[5] = '{8, 6, 2, 1, 0};
  lpc_bridge_general_control dut (.*);
  cpu_pci_agent far (.*);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite} <= {1'b1, 1'b0, w};
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    if (n >= 50) begin
      mismatches++;
      report_and_stop();
    end
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    `CHK({e, q}, {xe, x})
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  task automatic port_pulse(input logic f0);
    @(posedge pclk);
    {port_f0_write, port_60_read} <= {f0, !f0};
    @(posedge pclk);
    {port_f0_write, port_60_read} <= 2'b00;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    report_and_stop();
  end
  initial begin
    {presetn, rtc_rst_n, psel, penable, pwrite, port_f0_write, port_60_read} = 7'h0;
    paddr = '0;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    {presetn, rtc_rst_n} <= 2'b11;
    cyc(5);
    rd_chk(GENERAL_CONTROL_ADDR, 32'h0000_0000, 1'b0);
    rd_chk(GENERAL_STATUS_ADDR, 32'h0000_0f0a, 1'b0);
    rd_chk(12'h200, 32'h0000_0000, 1'b1);
    wr(GENERAL_CONTROL_ADDR, 32'hffff_ffff);
    rd_chk(GENERAL_CONTROL_ADDR, 32'h0000_3947, 1'b0);
    for (int i = 0; i < 5; i++) begin
      wr(GENERAL_CONTROL_ADDR, 32'h1 << bitpos[i]);
      cyc(1);
      `CHK({io_intctl_on, alternate_access_enable, dma_collect_buffer_enable, delayed_txn_enable,
            positive_decode_enable}, 5'h10 >> i)
    end
    wr(GENERAL_CONTROL_ADDR, 32'h0000_0040);
    wr(GENERAL_STATUS_ADDR, 32'h0000_1505);
    rd_chk(GENERAL_STATUS_ADDR, 32'h0000_1505, 1'b0);
    wr(GENERAL_CONTROL_ADDR, 32'h0000_0000);
    wr(GENERAL_STATUS_ADDR, 32'h0000_0500);
    rd_chk(GENERAL_STATUS_ADDR, 32'h0000_0505, 1'b0);
    @(posedge pclk);
    presetn <= 1'b0;
    cyc(2);
    presetn <= 1'b1;
    cyc(5);
    rd_chk(GENERAL_STATUS_ADDR, 32'h0000_050a, 1'b0);
    far.set_pin(PIN_FP_ERR_N, 1'b0);
    cyc(6);
    `CHK({irq13_out, ignore_numeric_error_out_n}, 2'b01)
    wr(GENERAL_CONTROL_ADDR, 32'h0000_2000);
    cyc(6);
    `CHK({irq13_out, ignore_numeric_error_out_n}, 2'b10)
    far.set_pin(PIN_FP_ERR_N, 1'b1);
    cyc(6);
    `CHK({irq13_out, ignore_numeric_error_out_n, irq_out}, 3'b110)
    wr(EV_MASK_ADDR, 32'h0000_000f);
    cyc(2);
    `CHK(irq_out, 1'b1)
    wr(GENERAL_CONTROL_ADDR, 32'h0000_2040);
    rd_chk(EV_STA_ADDR, 32'h0000_0001, 1'b0);
    wr(GENERAL_CONTROL_ADDR, 32'h0000_2000);
    rd_chk(EV_STA_ADDR, 32'h0000_0001, 1'b0);
    cyc(2);
    `CHK(irq_out, 1'b0)
    port_pulse(1'b1);
    cyc(3);
    `CHK(irq13_out, 1'b0)
    for (int i = 0; i < 2; i++) begin
      wr(GENERAL_CONTROL_ADDR, 32'h0000_1000 >> i);
      far.set_pin(PIN_KBD + i, 1'b1);
      cyc(2);
      far.set_pin(PIN_KBD + i, 1'b0);
      cyc(6);
      `CHK({irq1_out, irq12_out}, 2'b10 >> i)
      rd_chk(EV_STA_ADDR, 32'h0000_0002 << i, 1'b0);
      port_pulse(1'b0);
      cyc(3);
      `CHK({irq1_out, irq12_out}, 2'b00)
      wr(GENERAL_CONTROL_ADDR, 32'h0000_0000);
      far.set_pin(PIN_KBD + i, 1'b1);
      cyc(6);
      `CHK({irq1_out, irq12_out}, 2'b10 >> i)
      far.set_pin(PIN_KBD + i, 1'b0);
      cyc(6);
      `CHK({irq1_out, irq12_out}, 2'b00)
    end
    wr(GENERAL_STATUS_ADDR, 32'h0000_1f00);
    far.set_pin(PIN_CPU_RST_N, 1'b0);
    cyc(6);
    `CHK(cpu_init_out_n, 1'b0)
    rd_chk(EV_STA_ADDR, 32'h0000_0008, 1'b0);
    far.set_pin(PIN_CPU_RST_N, 1'b1);
    cyc(2);
    `CHK(cpu_init_out_n, 1'b0)
    cyc(8);
    `CHK(cpu_init_out_n, 1'b1)
    wr(GENERAL_STATUS_ADDR, 32'h0000_0f00);
    far.set_pin(PIN_CPU_RST_N, 1'b0);
    cyc(6);
    `CHK(cpu_init_out_n, 1'b1)
    far.set_pin(PIN_CPU_RST_N, 1'b1);
    for (int p = 0; p < 2; p++) begin
      wr(GENERAL_CONTROL_ADDR, 32'(p));
      for (int k = 0; k < 4; k++) begin
        far.pci_cycle(k[1], k[0], k);
        `CHK({claim_positive, claim_subtractive}, {k != 0, k == 0 && p == 0})
      end
    end
    report_and_stop();
  end
endmodule // lpc_bridge_general_control_tb
